/* seq_ts_regs.vh */
`ifndef SEQ_TS_REGS_VH
`define SEQ_TS_REGS_VH

// register offsets, high byte then low byte per channel
`define CH1_SEQUENCE_TIMESTAMP_HIGH_OFS 8'h90
`define CH1_SEQUENCE_TIMESTAMP_LOW_OFS 8'h91
`define CH2_SEQUENCE_TIMESTAMP_HIGH_OFS 8'h92
`define CH2_SEQUENCE_TIMESTAMP_LOW_OFS 8'h93
`define CH3_SEQUENCE_TIMESTAMP_HIGH_OFS 8'h94
`define CH3_SEQUENCE_TIMESTAMP_LOW_OFS 8'h95

// field layout of each byte register
`define TS_BYTE_MSB 7
`define TS_BYTE_LSB 0
`define TS_WIDTH 16

// reset values
`define SEQUENCE_TIMESTAMP_RESET 16'h0000
`define UNMAPPED_READ_VALUE 8'h00

// sequence command codes of the activation and sleep command fields
`define SEQ_CMD_POWER_ON_OR_EXIT 2'h1
`define SEQ_CMD_POWER_OFF_OR_ENTRY 2'h2

// timing
`define REF_CLK_PERIOD_NS 20
`define SEQUENCE_TICK_PERIOD_NS 50000
`define SEQUENCE_TIMER_MAX 16'hFFFF

`endif

/* seq_tick_gen.v */
`timescale 1ns/10ps
`include "seq_ts_regs.vh"

// divides ref_clk down to one pulse per sequence tick
module seq_tick_gen (
  input wire ref_clk,
  input wire rstn,
  input wire restart,
  input wire run,
  output reg tick
);

  // exact period: both figures are whole ns, so the division is exact here
  localparam integer TICK_CYCLES_INT = `SEQUENCE_TICK_PERIOD_NS / `REF_CLK_PERIOD_NS;
  localparam [11:0] TICK_CYCLES = TICK_CYCLES_INT[11:0];

  reg [11:0] div_reg;
  reg [11:0] div_next;
  reg tick_next;

  // restart aligns the first tick a full period after the trigger
  always @* begin
    div_next = div_reg;
    tick_next = 1'b0;
    if (restart) begin
      div_next = 12'h000;
    end else if (run) begin
      if (div_reg == TICK_CYCLES - 12'h001) begin
        div_next = 12'h000;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 12'h001;
      end
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 12'h000;
      tick <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick <= tick_next;
    end
  end

endmodule

/* sequence_timestamp_capture.v */
`timescale 1ns/10ps
`include "seq_ts_regs.vh"

// What this block does
// - each channel keeps its timestamp as read-only high and low byte registers.
// - stored value is the sequence timer when that channel is assigned its time.
// - command 01: capture when rising voltage passes undervoltage low-fault threshold.
// - command 10: capture when falling voltage passes the 200mV off threshold.
// - one timer count equals one 50 microsecond tick.
// - channel 1 high byte at 0x90, low byte at 0x91.
module sequence_timestamp_capture (
  input wire ref_clk,
  input wire rstn,
  input wire seq_trigger,
  input wire [1:0] activation_sequence_command,
  input wire [2:0] rise_past_uv_strobe,
  input wire [2:0] fall_past_off_strobe,
  input wire rd_en,
  input wire [7:0] rd_addr,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg seq_active,
  output reg [2:0] capture_done
);

  localparam NUM_CH = 3;

  // sequence states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RISING = 2'b01;
  localparam [1:0] ST_FALLING = 2'b10;

  // register map lookup: {hit, is_low, channel index}
  function [3:0] decode_addr;
    input [7:0] addr;
    begin
      case (addr)
        `CH1_SEQUENCE_TIMESTAMP_HIGH_OFS: decode_addr = 4'h8;
        `CH1_SEQUENCE_TIMESTAMP_LOW_OFS: decode_addr = 4'hC;
        `CH2_SEQUENCE_TIMESTAMP_HIGH_OFS: decode_addr = 4'h9;
        `CH2_SEQUENCE_TIMESTAMP_LOW_OFS: decode_addr = 4'hD;
        `CH3_SEQUENCE_TIMESTAMP_HIGH_OFS: decode_addr = 4'hA;
        `CH3_SEQUENCE_TIMESTAMP_LOW_OFS: decode_addr = 4'hE;
        default: decode_addr = 4'h0;
      endcase
    end
  endfunction

  // the two command codes that open a sequence
  function is_seq_code;
    input [1:0] code;
    begin
      is_seq_code = (code == `SEQ_CMD_POWER_ON_OR_EXIT) ||
        (code == `SEQ_CMD_POWER_OFF_OR_ENTRY);
    end
  endfunction

  // strobe set that qualifies for a sequence kind; idle passes nothing
  function [2:0] pick_crossing;
    input [1:0] mode;
    input [2:0] rise;
    input [2:0] fall;
    begin
      case (mode)
        ST_RISING: pick_crossing = rise;
        ST_FALLING: pick_crossing = fall;
        default: pick_crossing = 3'b000;
      endcase
    end
  endfunction

  // sequence state, timer and per-cycle capture decisions
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] timer_reg;
  reg [15:0] timer_next;
  reg [2:0] done_next;
  wire tick;
  wire start_ok;
  wire [1:0] mode_eff;
  wire [2:0] crossing;
  wire [2:0] capture_now;

  // any other command code leaves the block untouched
  assign start_ok = seq_trigger && is_seq_code(activation_sequence_command);

  // mode in force this cycle; a fresh trigger takes effect at once
  assign mode_eff = start_ok ? activation_sequence_command : state_reg;

  // pick the crossing that qualifies for the running sequence kind
  assign crossing = pick_crossing(mode_eff, rise_past_uv_strobe, fall_past_off_strobe);

  // first qualifying crossing only; a trigger re-arms every channel
  assign capture_now = crossing & (start_ok ? 3'b111 : ~capture_done);

  seq_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .restart(start_ok),
    .run(state_reg != ST_IDLE),
    .tick(tick)
  );

  // sequence state; ends when every channel has its time or timer saturates
  always @* begin
    state_next = state_reg;
    done_next = capture_done;
    if (start_ok) begin
      state_next = activation_sequence_command;
      done_next = 3'b000;
    end
    done_next = done_next | capture_now; // set wins over the trigger clear
    if (!start_ok && (state_reg != ST_IDLE)) begin
      if ((done_next == 3'b111) || (timer_reg == `SEQUENCE_TIMER_MAX)) begin
        state_next = ST_IDLE;
      end
    end
    case (state_next)
      ST_IDLE: state_next = ST_IDLE;
      ST_RISING: state_next = ST_RISING;
      ST_FALLING: state_next = ST_FALLING;
      default: state_next = ST_IDLE;
    endcase
  end

  // sequence timer in ticks; saturates instead of wrapping so a late
  // capture never looks early
  always @* begin
    timer_next = timer_reg;
    if (start_ok) begin
      timer_next = 16'h0000;
    end else if ((state_reg != ST_IDLE) && tick &&
                 (timer_reg != `SEQUENCE_TIMER_MAX)) begin
      timer_next = timer_reg + 16'h0001;
    end
  end

  // registered state; seq_active follows the next state so it rises
  // one edge after the trigger, not two
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      timer_reg <= 16'h0000;
      capture_done <= 3'b000;
      seq_active <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      capture_done <= done_next;
      seq_active <= (state_next != ST_IDLE);
    end
  end

  // per-channel timestamp holders
  wire [15:0] ts_flat [0:NUM_CH-1];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
      reg [15:0] ts_reg;
      // a trigger-cycle crossing stores zero, the cleared timer value
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          ts_reg <= `SEQUENCE_TIMESTAMP_RESET;
        end else if (capture_now[gi]) begin
          ts_reg <= start_ok ? 16'h0000 : timer_reg;
        end
      end
      assign ts_flat[gi] = ts_reg;
    end
  endgenerate

  // read port; reading a high byte snapshots its low byte so the pair
  // stays coherent even if a capture lands between the two reads
  reg [7:0] shadow_low_reg;
  reg [1:0] shadow_ch_reg;
  reg shadow_valid_reg;
  reg [3:0] dec;
  reg [15:0] sel_ts;
  reg [7:0] rd_data_next;

  always @* begin
    dec = decode_addr(rd_addr);
    sel_ts = ts_flat[0];
    if (dec[1:0] == 2'h1) begin
      sel_ts = ts_flat[1];
    end else if (dec[1:0] == 2'h2) begin
      sel_ts = ts_flat[2];
    end
    rd_data_next = `UNMAPPED_READ_VALUE;
    if (dec[3]) begin
      if (!dec[2]) begin
        rd_data_next = sel_ts[15:8];
      end else if (shadow_valid_reg && (shadow_ch_reg == dec[1:0])) begin
        rd_data_next = shadow_low_reg;
      end else begin
        rd_data_next = sel_ts[7:0];
      end
    end
  end

  // read data and low-byte snapshot, updated only on a read; rd_valid follows rd_en every cycle
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `UNMAPPED_READ_VALUE;
      rd_valid <= 1'b0;
      shadow_low_reg <= 8'h00;
      shadow_ch_reg <= 2'h0;
      shadow_valid_reg <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_data_next;
        if (dec[3] && !dec[2]) begin
          shadow_low_reg <= sel_ts[7:0];
          shadow_ch_reg <= dec[1:0];
          shadow_valid_reg <= 1'b1;
        end else if (dec[3]) begin
          shadow_valid_reg <= 1'b0; // one low read consumes the snapshot
        end
      end
    end
  end

endmodule

/* sequence_timestamp_capture_monitor.sv */
`timescale 1ns/10ps
module sequence_timestamp_capture_monitor (
  input wire ref_clk,
  input wire rstn,
  input wire seq_trigger,
  input wire [1:0] activation_sequence_command,
  input wire [2:0] rise_past_uv_strobe,
  input wire [2:0] fall_past_off_strobe,
  input wire rd_en,
  input wire [7:0] rd_addr,
  input wire [7:0] rd_data,
  input wire rd_valid,
  input wire seq_active,
  input wire [2:0] capture_done
);
  wire go;
  wire [2:0] stb;
  // only codes 01 and 10 may start a sequence
  assign go = seq_trigger && (activation_sequence_command == 2'h1
    || activation_sequence_command == 2'h2);
  assign stb = rise_past_uv_strobe | fall_past_off_strobe;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  read_answer_a:
    assert property (rd_en |=> rd_valid) else $error("read not answered");
  read_quiet_a:
    assert property (!rd_en |=> !rd_valid && $stable(rd_data)) else $error("spurious read");
  unmapped_zero_a:
    assert property (rd_en && (rd_addr < 8'h90 || rd_addr > 8'h95) |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
  start_clear_a:
    assert property (go && stb == 3'h0 |=> seq_active && capture_done == 3'h0)
      else $error("trigger did not restart");
  idle_hold_a:
    assert property (!seq_active && !go |=> !seq_active) else $error("sequence without trigger");
  done_cause_a:
    assert property ((capture_done & ~$past(capture_done) & ~$past(stb)) == 3'h0)
      else $error("capture without strobe");
  idle_frozen_a:
    assert property (!seq_active && !seq_trigger |=> $stable(capture_done))
      else $error("capture while idle");
  cover property (go);
  cover property (capture_done == 3'h7);
  cover property (rd_en && rd_addr == 8'h90);
endmodule
bind sequence_timestamp_capture sequence_timestamp_capture_monitor i_mon (
  .ref_clk(ref_clk), .rstn(rstn), .seq_trigger(seq_trigger),
  .activation_sequence_command(activation_sequence_command),
  .rise_past_uv_strobe(rise_past_uv_strobe), .fall_past_off_strobe(fall_past_off_strobe),
  .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
  .seq_active(seq_active), .capture_done(capture_done));

/* sequence_timestamp_capture_test.sv */
`timescale 1ns/10ps
module sequence_timestamp_capture_test;
  reg ref_clk = 0;
  reg rstn = 0;
  reg seq_trigger = 0;
  reg [1:0] cmd = 0;
  reg [2:0] rise = 0;
  reg [2:0] fall = 0;
  reg rd_en = 0;
  reg [7:0] rd_addr = 0;
  wire [7:0] rd_data;
  wire rd_valid;
  wire seq_active;
  wire [2:0] capture_done;
  integer err_count = 0;
  integer total_checks = 0;
  reg [15:0] got;
  reg [2:0] w;
  integer i, n, el, s;

  sequence_timestamp_capture i_dut (.ref_clk(ref_clk), .rstn(rstn),
    .seq_trigger(seq_trigger), .activation_sequence_command(cmd),
    .rise_past_uv_strobe(rise), .fall_past_off_strobe(fall), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .seq_active(seq_active), .capture_done(capture_done));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // timer count seen c cycles after the trigger edge, one count per 2500 cycles
  function [15:0] exp_ts(input integer c);
    exp_ts = c / 2500;
  endfunction

  task chk(input string w, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", w, e, g);
      end
    end
  endtask

  task give_verdict;
    begin
      if (err_count == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // answer is registered, so it is settled by the next falling edge;
  // a quiet cycle follows so back-to-back calls always drop rd_en low between reads
  task rd(input [7:0] a, output [7:0] d);
    begin
      rd_en = 1;
      rd_addr = a;
      @(negedge ref_clk);
      chk("rd_valid", 16'h0001, {15'h0, rd_valid});
      d = rd_data;
      rd_en = 0;
      @(negedge ref_clk);
    end
  endtask

  task trig(input [1:0] c);
    begin
      seq_trigger = 1;
      cmd = c;
      @(negedge ref_clk);
      chk("active", {15'h0, c == 2'h1 || c == 2'h2}, {15'h0, seq_active});
      if (c == 2'h1 || c == 2'h2)
        chk("done", 16'h0000, {13'h0, capture_done});
      seq_trigger = 0;
      @(negedge ref_clk);
    end
  endtask

  task strobe(input [2:0] r, input [2:0] f);
    begin
      rise = r;
      fall = f;
      @(negedge ref_clk);
      rise = 0;
      fall = 0;
      @(negedge ref_clk);
    end
  endtask

  // wrong-kind strobe first, then the real one, each channel in its own tick window
  task run_seq(input [1:0] c);
    reg [15:0] e [0:2];
    begin
      trig(c);
      el = 1;
      for (i = 0; i < 3; i = i + 1) begin
        n = (2 * i + $urandom % 2) * 2500 + 500 + $urandom % 1500;
        repeat (n - 3 - el) @(negedge ref_clk);
        w = $urandom % 8;
        strobe(c == 2'h2 ? w : 3'h0, c == 2'h1 ? w : 3'h0);
        chk("done", (16'h1 << i) - 1, {13'h0, capture_done});
        strobe(c == 2'h1 ? 3'h1 << i : 3'h0, c == 2'h2 ? 3'h1 << i : 3'h0);
        el = n + 1;
        e[i] = exp_ts(n);
      end
      chk("done", 16'h0007, {13'h0, capture_done});
      strobe(3'h1, 3'h1);
      for (i = 0; i < 3; i = i + 1) begin
        rd(8'h90 + 2 * i, got[15:8]);
        rd(8'h91 + 2 * i, got[7:0]);
        chk("timestamp", e[i], got);
      end
      chk("active", 16'h0000, {15'h0, seq_active});
    end
  endtask

  initial begin
    s = $urandom(84848);
    repeat (12) @(negedge ref_clk);
    rstn = 1;
    // reset contents and the unmapped neighbours 0x8F, 0x96
    for (i = 0; i < 8; i = i + 1) begin
      rd(8'h8F + i, got[7:0]);
      chk("reset", 16'h0000, {8'h0, got[7:0]});
    end
    trig(2'h0);
    trig(2'h3);
    strobe(3'h7, 3'h7);
    chk("idle", 16'h0000, {13'h0, capture_done});
    run_seq(2'h1);
    trig(2'h2);
    repeat (3000) @(negedge ref_clk);
    strobe(3'h0, 3'h1);
    rd(8'h90, got[15:8]);
    rd(8'h91, got[7:0]);
    chk("timestamp", exp_ts(3002), got);
    run_seq(2'h2);
    // corner: a crossing in the trigger cycle itself stores zero
    seq_trigger = 1;
    cmd = 2'h1;
    rise = 3'h4;
    @(negedge ref_clk);
    seq_trigger = 0;
    rise = 0;
    chk("done", 16'h0004, {13'h0, capture_done});
    rd(8'h94, got[15:8]);
    rd(8'h95, got[7:0]);
    chk("timestamp", 16'h0000, got);
    give_verdict;
  end
endmodule
